// ===== ocdc_pkg.sv
// Purpose: Shared constants and types of the octal converter datapath
// Assumes: 32-bit AHB-Lite register bus, 12-bit codes, eight channels
// Notes:   Offsets are byte addresses
// Overview of operation
// - Per-channel zero and gain correction registers
// - Corrected code stored in channel data register
// - Input, gain or zero write recomputes channel
// - Gain coefficient spans half to one-and-half
// - Zero offset signed, -2048 to +2047 LSB
// - One shared engine serves channels in turn
// - Correction enable bit switches engine on/off
// - Disabled: pass data through, store gain/zero only
// - Code times (gain+2^11) over 2^12 plus zero
// - Reset gain 2048, zero 0, input 000h
// - Dual supply shift default 2458 or 2731
// - Gain select bit picks gain six or four
// - Single supply powers both shift converters down
// - Channels 0-3 group A, 4-7 group B
// - Format pin: low binary, high twos complement
// - Latch code selects channel converter tap
// - Gain always binary, zero always twos complement
// - Readback in the format written
// - Gain change reloads group shift defaults
package ocdc_pkg;
  localparam int          CH_N      = 8;
  localparam int          CODE_W    = 12;
  localparam int          ID_W      = 3;
  localparam int          GRP_SZ    = 4;
  localparam logic [7:0]  CFG_OFS   = 8'h00;
  localparam logic [7:0]  SHA_OFS   = 8'h04;
  localparam logic [7:0]  SHB_OFS   = 8'h08;
  localparam logic [7:0]  IN_BASE   = 8'h40;
  localparam logic [7:0]  GN_BASE   = 8'h60;
  localparam logic [7:0]  ZR_BASE   = 8'h80;
  localparam logic [7:0]  DR_BASE   = 8'ha0;
  localparam logic [7:0]  LT_BASE   = 8'hc0;
  localparam int          CE_BIT    = 0;
  localparam int          G4_BIT    = 1;
  localparam int          DUAL_BIT  = 2;
  localparam int          FMT_BIT   = 8;
  localparam int          BUSY_BIT  = 9;
  localparam logic [2:0]  CFG_RST   = 3'h4;
  localparam logic [11:0] GAIN_RST  = 12'h800;
  localparam logic [11:0] ZERO_RST  = 12'h000;
  localparam logic [11:0] IN_RST    = 12'h000;
  localparam logic [11:0] DR_RST    = 12'h000;
  localparam logic [11:0] SHIFT_G6  = 12'h99a;
  localparam logic [11:0] SHIFT_G4  = 12'haab;
  localparam logic [12:0] GAIN_BIAS = 13'h0800;
  localparam int          DIV_SH    = 12;
  localparam logic [11:0] CODE_MAX  = 12'hfff;

  typedef struct packed {
    logic [ID_W-1:0]   ch;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] gain;
    logic [CODE_W-1:0] zero;
  } ocdc_req_s;

  typedef struct packed {
    logic [ID_W-1:0]   ch;
    logic [CODE_W-1:0] code;
  } ocdc_res_s;

  // Twos complement and offset binary differ only in the MSB
  function automatic logic [CODE_W-1:0] fmt_flip(
    input logic [CODE_W-1:0] c, input logic twos);
    return c ^ {twos, {(CODE_W-1){1'b0}}};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return (a[7:5] == b[7:5]) && (a[1:0] == 2'h0);
  endfunction
endpackage

// ===== ocdc_corr_engine.sv
// Purpose: Shared gain and zero correction arithmetic
// Assumes: One request per cycle at most, result one cycle later
// Notes:   Codes in offset binary
`timescale 1ns/100ps
`default_nettype none
module ocdc_corr_engine (
  input  wire logic               mclk_in,
  input  wire logic               reset_n_in,
  input  wire logic               req_valid_in,
  input  wire ocdc_pkg::ocdc_req_s req_in,
  output logic                    res_valid_out,
  output ocdc_pkg::ocdc_res_s     res_out
);
  logic        [12:0] gsum;
  logic        [24:0] prod;
  logic        [12:0] scaled;
  logic signed [14:0] sum;
  logic        [11:0] sat;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    gsum   = {1'b0, req_in.gain} + ocdc_pkg::GAIN_BIAS;
    prod   = req_in.code * gsum;
    scaled = prod[24:ocdc_pkg::DIV_SH];
    sum    = $signed({2'h0, scaled})
           + $signed({{3{req_in.zero[11]}}, req_in.zero});
    if (sum < 0) begin
      sat = 12'h000;
    end else if (sum > $signed({3'h0, ocdc_pkg::CODE_MAX})) begin
      sat = ocdc_pkg::CODE_MAX;
    end else begin
      sat = sum[11:0];
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_valid_out <= 1'b0;
      res_out       <= '0;
    end else begin
      res_valid_out <= req_valid_in;
      res_out       <= '{ch: req_in.ch, code: sat};
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  AST_UNITY_GAIN: assert property (req_valid_in && req_in.gain == 12'h800
    && req_in.zero == 12'h000 |=> res_out.code == $past(req_in.code))
    else $error("Unity gain changed the code");
  AST_SAT_LOW: assert property (req_valid_in && req_in.code == 12'h000
    && req_in.zero[11] |=> res_valid_out && res_out.code == 12'h000)
    else $error("Negative result not clamped");
  // A large negative zero can pull the top result back inside the range
  AST_SAT_HIGH: assert property (req_valid_in && req_in.code == 12'hfff
    && req_in.gain == 12'hfff && !req_in.zero[11]
    |=> res_out.code == 12'hfff)
    else $error("Large result not clamped");
endmodule
`default_nettype wire

// ===== ocdc_req_queue.sv
// Purpose: Arrival-ordered queue of channel correction requests
// Assumes: At most one push and one pop per cycle
// Notes:   A channel already waiting is not queued twice
`timescale 1ns/100ps
`default_nettype none
module ocdc_req_queue #(
  parameter int DEPTH = 8,
  parameter int ID_W  = 3
) (
  input  wire logic            mclk_in,
  input  wire logic            reset_n_in,
  input  wire logic            push_in,
  input  wire logic [ID_W-1:0] push_id_in,
  input  wire logic            pop_in,
  output logic                 valid_out,
  output logic      [ID_W-1:0] id_out
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < (1 << ID_W) || DEPTH != (1 << PW)) begin : g_chk
    $error("Queue depth must be a power of two covering all ids");
  end
  logic [ID_W-1:0] mem_q [DEPTH];
  logic [PW-1:0]   rd_q;
  logic [PW-1:0]   wr_q;
  logic [PW:0]     cnt_q;
  logic [(1<<ID_W)-1:0] pend_q;
  logic            do_pop;
  logic            do_push;

  ////////////////////////////////////////////////////////////////////////
  assign valid_out = (cnt_q != '0);
  assign id_out    = mem_q[rd_q];
  assign do_pop    = pop_in && valid_out;
  // Same id leaving now must be queued again: its registers just changed
  assign do_push   = push_in && !(pend_q[push_id_in]
                     && !(do_pop && id_out == push_id_in));

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      rd_q  <= rd_q + PW'(do_pop);
      wr_q  <= wr_q + PW'(do_push);
      cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= push_id_in;
    end
  end

  for (genvar i = 0; i < (1 << ID_W); i++) begin : g_pend
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        pend_q[i] <= 1'b0;
      end else if (do_push && push_id_in == ID_W'(i)) begin
        pend_q[i] <= 1'b1;
      end else if (do_pop && id_out == ID_W'(i)) begin
        pend_q[i] <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  AST_NO_LOSS: assert property (push_in |=> pend_q[$past(push_id_in)])
    else $error("Request lost");
  AST_BOUND: assert property (cnt_q <= (PW+1)'(1 << ID_W))
    else $error("Queue holds more than one entry per id");
endmodule
`default_nettype wire

// ===== ocdc_top.sv
// Purpose: Octal converter datapath with correction and register bus
// Assumes: AHB-Lite slave, one wait state on a read right after a write, latches follow data registers
// Notes:   Shift, data and latch codes kept offset binary inside, converted at the bus; input codes stay as written
`timescale 1ns/100ps
`default_nettype none
module ocdc_top #(
  parameter int          CH_N     = 8,
  parameter logic [11:0] TRIM_G6_A = ocdc_pkg::SHIFT_G6,
  parameter logic [11:0] TRIM_G6_B = ocdc_pkg::SHIFT_G6,
  parameter logic [11:0] TRIM_G4_A = ocdc_pkg::SHIFT_G4,
  parameter logic [11:0] TRIM_G4_B = ocdc_pkg::SHIFT_G4
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        code_format_select_in,
  output logic      [95:0] channel_outputs_out,
  output logic      [23:0] group_shift_code_out,
  output logic      [1:0]  shift_pd_out,
  output logic             gain4_sel_out
);
  if (CH_N != ocdc_pkg::CH_N) begin : g_chk
    $error("Address map serves exactly eight channels");
  end

  logic [2:0]  fmt_sync_q;
  logic        fmt_q;
  logic [2:0]  cfg_q;
  logic [11:0] shift_q [2];
  logic [11:0] in_q    [CH_N];
  logic [11:0] gn_q    [CH_N];
  logic [11:0] zr_q    [CH_N];
  logic [11:0] dr_q    [CH_N];
  logic [11:0] lt_q    [CH_N];
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic        acc;
  logic        rd_req;
  logic        ce;
  logic [2:0]  wch;
  logic [11:0] wdat;
  logic        w_in;
  logic        w_gn;
  logic        w_zr;
  logic        w_dr;
  logic        w_cfg;
  logic        push;
  logic        q_valid;
  logic [2:0]  q_id;
  logic        res_valid;
  ocdc_pkg::ocdc_req_s req;
  ocdc_pkg::ocdc_res_s res;

  ////////////////////////////////////////////////////////////////////////
  // Format pin: first stage feeds only the second
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_sync_q <= 3'h0;
      fmt_q      <= 1'b0;
    end else begin
      fmt_sync_q <= {fmt_sync_q[1:0], code_format_select_in};
      if (fmt_sync_q[1] == fmt_sync_q[2]) begin
        fmt_q <= fmt_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  assign acc    = hsel_in && htrans_in[1] && hready_in;
  // No hready in here: it would loop through the bus back to itself
  assign rd_req = hsel_in && htrans_in[1] && !hwrite_in;
  // One wait state lets a read see the write just ahead of it
  assign hreadyout_out = !(wr_q && rd_req);
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc && hwrite_in && (haddr_in[31:8] == 24'h000000);
      if (acc && hwrite_in) begin
        wa_q <= haddr_in[7:0];
      end
    end
  end

  assign ce    = cfg_q[ocdc_pkg::CE_BIT];
  assign wch   = wa_q[4:2];
  assign wdat  = hwdata_in[11:0];
  assign w_in  = wr_q && ocdc_pkg::hit(wa_q, ocdc_pkg::IN_BASE);
  assign w_gn  = wr_q && ocdc_pkg::hit(wa_q, ocdc_pkg::GN_BASE);
  assign w_zr  = wr_q && ocdc_pkg::hit(wa_q, ocdc_pkg::ZR_BASE);
  assign w_dr  = wr_q && ocdc_pkg::hit(wa_q, ocdc_pkg::DR_BASE);
  assign w_cfg = wr_q && wa_q == ocdc_pkg::CFG_OFS;

  always_comb begin
    logic [7:0] a;
    logic [2:0] c;
    a = haddr_in[7:0];
    c = haddr_in[4:2];
    hrdata_d = 32'h00000000;
    if (haddr_in[31:8] != 24'h000000) begin
      hrdata_d = 32'h00000000;
    end else if (a == ocdc_pkg::CFG_OFS) begin
      hrdata_d[2:0] = cfg_q;
      hrdata_d[ocdc_pkg::FMT_BIT]  = fmt_q;
      hrdata_d[ocdc_pkg::BUSY_BIT] = q_valid || res_valid;
    end else if (a == ocdc_pkg::SHA_OFS) begin
      hrdata_d[11:0] = ocdc_pkg::fmt_flip(shift_q[0], fmt_q);
    end else if (a == ocdc_pkg::SHB_OFS) begin
      hrdata_d[11:0] = ocdc_pkg::fmt_flip(shift_q[1], fmt_q);
    end else if (ocdc_pkg::hit(a, ocdc_pkg::IN_BASE)) begin
      hrdata_d[11:0] = in_q[c];
    end else if (ocdc_pkg::hit(a, ocdc_pkg::GN_BASE)) begin
      hrdata_d[11:0] = gn_q[c];
    end else if (ocdc_pkg::hit(a, ocdc_pkg::ZR_BASE)) begin
      hrdata_d[11:0] = zr_q[c];
    end else if (ocdc_pkg::hit(a, ocdc_pkg::DR_BASE)) begin
      hrdata_d[11:0] = ocdc_pkg::fmt_flip(dr_q[c], fmt_q);
    end else if (ocdc_pkg::hit(a, ocdc_pkg::LT_BASE)) begin
      hrdata_d[11:0] = ocdc_pkg::fmt_flip(lt_q[c], fmt_q);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_q <= 32'h00000000;
    end else if (acc && !hwrite_in) begin
      hrdata_q <= hrdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration and group shift codes
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= ocdc_pkg::CFG_RST;
    end else if (w_cfg) begin
      cfg_q <= hwdata_in[2:0];
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_q[0] <= TRIM_G6_A;
      shift_q[1] <= TRIM_G6_B;
    end else if (w_cfg && hwdata_in[ocdc_pkg::G4_BIT]
                 != cfg_q[ocdc_pkg::G4_BIT]) begin
      shift_q[0] <= hwdata_in[ocdc_pkg::G4_BIT] ? TRIM_G4_A
                                               : TRIM_G6_A;
      shift_q[1] <= hwdata_in[ocdc_pkg::G4_BIT] ? TRIM_G4_B
                                               : TRIM_G6_B;
    end else if (wr_q && wa_q == ocdc_pkg::SHA_OFS) begin
      shift_q[0] <= ocdc_pkg::fmt_flip(wdat, fmt_q);
    end else if (wr_q && wa_q == ocdc_pkg::SHB_OFS) begin
      shift_q[1] <= ocdc_pkg::fmt_flip(wdat, fmt_q);
    end
  end

  assign group_shift_code_out = {shift_q[1], shift_q[0]};
  // Single supply: both shift converters off
  assign shift_pd_out  = {2{!cfg_q[ocdc_pkg::DUAL_BIT]}};
  assign gain4_sel_out = cfg_q[ocdc_pkg::G4_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Channel registers; engine result wins over a same-cycle direct write
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        in_q[i] <= ocdc_pkg::IN_RST;
        gn_q[i] <= ocdc_pkg::GAIN_RST;
        zr_q[i] <= ocdc_pkg::ZERO_RST;
      end else if (wch == 3'(i)) begin
        if (w_in) begin
          in_q[i] <= wdat;
        end
        if (w_gn) begin
          gn_q[i] <= wdat;
        end
        if (w_zr) begin
          zr_q[i] <= wdat;
        end
      end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        dr_q[i] <= ocdc_pkg::DR_RST;
      end else if (res_valid && res.ch == 3'(i)) begin
        dr_q[i] <= res.code;
      end else if (wch == 3'(i) && (w_dr || (w_in && !ce))) begin
        dr_q[i] <= ocdc_pkg::fmt_flip(wdat, fmt_q);
      end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        lt_q[i] <= ocdc_pkg::DR_RST;
      end else begin
        lt_q[i] <= dr_q[i];
      end
    end

    // Channels 0-3 group A, 4-7 group B, by bit order
    assign channel_outputs_out[i*12 +: 12] = lt_q[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // Correction requests and the shared engine
  assign push = wr_q && ce && (w_in || w_gn || w_zr);

  ocdc_req_queue #(
    .DEPTH (ocdc_pkg::CH_N),
    .ID_W  (ocdc_pkg::ID_W)
  ) u_queue (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .push_in    (push),
    .push_id_in (wch),
    .pop_in     (1'b1),
    .valid_out  (q_valid),
    .id_out     (q_id)
  );

  always_comb begin
    req.ch   = q_id;
    req.code = ocdc_pkg::fmt_flip(in_q[q_id], fmt_q);
    req.gain = gn_q[q_id];
    req.zero = zr_q[q_id];
  end

  ocdc_corr_engine u_engine (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .req_valid_in  (q_valid),
    .req_in        (req),
    .res_valid_out (res_valid),
    .res_out       (res)
  );

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  AST_LATCH_FOLLOW: assert property (1'b1 |=> lt_q[0] == $past(dr_q[0])
    && lt_q[7] == $past(dr_q[7]))
    else $error("Latch did not follow data register");
  AST_DIRECT_PASS: assert property (w_in && !ce && wch == 3'h2
    && !(res_valid && res.ch == 3'h2) |=> dr_q[2]
    == ocdc_pkg::fmt_flip($past(wdat), $past(fmt_q)))
    else $error("Disabled write not passed through");
  AST_NO_CALC_OFF: assert property (wr_q && !ce |-> !push)
    else $error("Calculation started while disabled");
  AST_RECOMPUTE: assert property (wr_q && ce && (w_gn || w_zr)
    |-> ##[1:9] res_valid && res.ch == $past(wch))
    else $error("Write did not lead to recompute");
  AST_ENG_LAT: assert property (q_valid |=> res_valid)
    else $error("Engine result missing");
  AST_RELOAD: assert property (w_cfg && hwdata_in[1] && !cfg_q[1]
    |=> shift_q[0] == TRIM_G4_A && shift_q[1] == TRIM_G4_B)
    else $error("Shift codes not reloaded on gain change");
  AST_PD: assert property ($fell(cfg_q[2]) |-> shift_pd_out == 2'h3)
    else $error("Shift converters not powered down");
  AST_RD_STALL: assert property (wr_q && rd_req |-> !hreadyout_out
    ##1 hreadyout_out)
    else $error("Read stall not exactly one cycle");
  CV_CORR: cover property (push ##[1:3] res_valid);
  CV_MULTI: cover property (q_valid && push && q_id != wch);
  CV_GAIN4: cover property (w_cfg ##1 gain4_sel_out);
  CV_STALL: cover property (wr_q && rd_req);
endmodule
`default_nettype wire

// ===== ocdc_host_bfm.sv
// Purpose: AHB-Lite host model driving the datapath register bus
// Assumes: Single word transfers, slave answers OKAY
// Notes:   Waits on hready unbounded; the bench watchdog bounds it
`timescale 1ns/100ps
`default_nettype none
module ocdc_host_bfm (
  input  wire logic        mclk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h00000000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call just after a rising edge; returns at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel_out   <= 1'b1;
    haddr_out  <= {24'h000000, a};
    htrans_out <= 2'h2;
    hwrite_out <= w;
    hsize_out  <= 3'h2;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hsel_out   <= 1'b0;
    hwdata_out <= wd;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
  endtask
endmodule
`default_nettype wire

// ===== tb_octal_dac_calibration_datapath.sv
// Purpose: Self-checking bench of the octal converter datapath
// Assumes: Host model owns the bus; format pin driven here
// Notes:   Expected codes come from a shadow of gain and zero
`timescale 1ns/100ps
`default_nettype none
module tb_octal_dac_calibration_datapath;
  logic        mclk_in, reset_n_in, hsel, hwrite, hready, hresp;
  logic        fmt, g4;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, shift_pd;
  logic [2:0]  hsize;
  logic [95:0] chan;
  logic [23:0] shift;
  logic [11:0] gn [8];
  logic [11:0] zr [8];
  logic [35:0] cases [6];
  logic [11:0] xv;
  int          n_mismatch, comparisons;

  ocdc_top DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .code_format_select_in(fmt),
    .channel_outputs_out(chan), .group_shift_code_out(shift),
    .shift_pd_out(shift_pd), .gain4_sel_out(g4));

  ocdc_host_bfm host (.mclk_in(mclk_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Generous: the sequence needs well under 2000 cycles
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.xfer(1'b0, a, 32'h00000000, d);
    chk_pin(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    host.xfer(1'b1, a, d, dummy);
    // Register lands at the return edge; pins settle one edge later
    @(posedge mclk_in);
  endtask

  task automatic set_cal(input int c, input logic [11:0] g, z);
    wr(ocdc_pkg::GN_BASE + 8'(4 * c), {20'h00000, g});
    wr(ocdc_pkg::ZR_BASE + 8'(4 * c), {20'h00000, z});
    gn[c] = g;
    zr[c] = z;
  endtask

  // Gain is binary, zero twos complement; clamp, never wrap
  function automatic logic [11:0] corr(input logic [11:0] x, g, z);
    int v;
    v = ((int'(x) * (int'(g) + 2048)) >>> 12) + int'(signed'(z));
    if (v > 4095) v = 4095;
    if (v < 0) v = 0;
    return 12'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_in = 1'b0;
    fmt = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cases = '{36'h000000ffe, 36'hfff000800, 36'h8007ff400,
              36'h800800c00, 36'hfff001fff, 36'h800800100};
    for (int c = 0; c < 8; c++) begin
      gn[c] = 12'h800;
      zr[c] = 12'h000;
    end
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    chk_pin(chan[31:0], 32'h00000000);
    chk_pin(chan[63:32], 32'h00000000);
    chk_pin(chan[95:64], 32'h00000000);
    chk_pin(shift, {12'd2458, 12'd2458});
    chk_pin({g4, shift_pd}, 3'h0);
    chk_reg(ocdc_pkg::CFG_OFS, 32'h00000004);
    for (int c = 0; c < 8; c++) begin
      chk_reg(ocdc_pkg::GN_BASE + 8'(4 * c), 32'h00000800);
      chk_reg(ocdc_pkg::ZR_BASE + 8'(4 * c), 32'h00000000);
      chk_reg(ocdc_pkg::IN_BASE + 8'(4 * c), 32'h00000000);
    end
    wr(8'h3c, 32'hffffffff);
    chk_reg(8'h3c, 32'h00000000);
    chk_pin(hresp, 1'b0);
    $display("test reset done");

    // Engine off: data goes straight through, cal only stored
    wr(ocdc_pkg::DR_BASE + 8'h04, 32'h00000123);
    repeat (2) @(posedge mclk_in);
    chk_pin(chan[23:12], 12'h123);
    wr(ocdc_pkg::IN_BASE + 8'h08, 32'h00000456);
    repeat (2) @(posedge mclk_in);
    chk_pin(chan[35:24], 12'h456);
    set_cal(1, 12'hfff, 12'h7ff);
    chk_reg(ocdc_pkg::GN_BASE + 8'h04, 32'h00000fff);
    chk_reg(ocdc_pkg::ZR_BASE + 8'h04, 32'h000007ff);
    chk_pin(chan[23:12], 12'h123);
    $display("test bypass done");

    // Engine on: gain span, zero span and clamping on one channel
    wr(ocdc_pkg::CFG_OFS, 32'h00000005);
    for (int i = 0; i < 6; i++) begin
      set_cal(3, cases[i][35:24], cases[i][23:12]);
      wr(ocdc_pkg::IN_BASE + 8'h0c, {20'h00000, cases[i][11:0]});
      repeat (4) @(posedge mclk_in);
      xv = corr(cases[i][11:0], gn[3], zr[3]);
      chk_reg(ocdc_pkg::DR_BASE + 8'h0c, {20'h00000, xv});
      chk_pin(chan[47:36], xv);
    end
    $display("test correction done");

    // All channels back to back through the shared engine
    for (int c = 0; c < 8; c++) begin
      wr(ocdc_pkg::IN_BASE + 8'(4 * c), 32'(c * 500 + 100));
    end
    repeat (4) @(posedge mclk_in);
    for (int c = 0; c < 8; c++) begin
      xv = 12'(c * 500 + 100);
      chk_pin(chan[12 * c +: 12], corr(xv, gn[c], zr[c]));
    end
    $display("test queue done");

    // Gain select, group shift codes and supply mode
    wr(ocdc_pkg::CFG_OFS, 32'h00000007);
    chk_pin(g4, 1'b1);
    chk_reg(ocdc_pkg::SHA_OFS, 32'd2731);
    chk_pin(shift, {12'd2731, 12'd2731});
    wr(ocdc_pkg::SHA_OFS, 32'h00000111);
    wr(ocdc_pkg::SHB_OFS, 32'h00000222);
    chk_pin(shift, 24'h222111);
    wr(ocdc_pkg::CFG_OFS, 32'h00000005);
    chk_pin({g4, shift}, {1'b0, 12'd2458, 12'd2458});
    wr(ocdc_pkg::CFG_OFS, 32'h00000001);
    chk_pin(shift_pd, 2'h3);
    wr(ocdc_pkg::CFG_OFS, 32'h00000005);
    chk_pin(shift_pd, 2'h0);
    $display("test gain select done");

    // Twos complement pin: data flips, cal registers stay raw
    fmt <= 1'b1;
    repeat (6) @(posedge mclk_in);
    wr(ocdc_pkg::CFG_OFS, 32'h00000004);
    chk_reg(ocdc_pkg::CFG_OFS, 32'h00000104);
    wr(ocdc_pkg::DR_BASE + 8'h14, 32'h00000000);
    repeat (2) @(posedge mclk_in);
    chk_pin(chan[71:60], 12'h800);
    chk_reg(ocdc_pkg::DR_BASE + 8'h14, 32'h00000000);
    set_cal(5, 12'h123, 12'h456);
    chk_reg(ocdc_pkg::GN_BASE + 8'h14, 32'h00000123);
    chk_reg(ocdc_pkg::ZR_BASE + 8'h14, 32'h00000456);
    $display("test format done");
    end_of_test();
  end
endmodule
`default_nettype wire
